// >>> sim/ptu_enc_model.sv
// Quadrature encoder model driving one pair of phase inputs
`timescale 1ns/1ps
module ptu_enc_model #(
   parameter int HOLD = 8
) (
   input  wire logic pclk,
   input  wire logic go,
   input  wire logic up,
   output logic      ph_a,
   output logic      ph_b,
   output logic      busy
);
   // ***************************************************************
   // Stepping
   // ***************************************************************
   // Every level stands HOLD cycles, well past the minimum pulse and overlap
   initial
   begin
      ph_a = 1'b0;
      ph_b = 1'b0;
      busy = 1'b0;
      forever
      begin
         @(posedge pclk);
         if (go)
         begin
            busy <= 1'b1;
            // Phase A edge only lines up the phases; it must not count
            if ((ph_a != ph_b) != up)
            begin
               ph_a <= ~ph_a;
               repeat (HOLD) @(posedge pclk);
            end
            ph_b <= ~ph_b;
            repeat (HOLD) @(posedge pclk);
            busy <= 1'b0;
         end
      end
   end
endmodule : ptu_enc_model

// >>> sim/ptu_tb_top.sv
// Self-checking bench for the pulse timer unit
`timescale 1ns/1ps
module ptu_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ph_a;
   logic        ph_b;
   logic        ph_c;
   logic        ph_d;
   logic [2:0]  timer_io_pin;
   logic [2:0]  adc_start_req;
   logic [7:0]  match_capture_irq;
   logic [2:0]  overflow_irq;
   logic [1:0]  underflow_irq;
   logic [3:0]  irq_source;
   logic        irq;
   logic [2:1]  go;
   logic [2:1]  busy;
   logic        up;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          adc_n = 0;
   time         t_last;
   time         t_prev;

   ptu_top i_ptu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clock_in_a(ph_a), .ext_clock_in_b(ph_b), .ext_clock_in_c(ph_c), .ext_clock_in_d(ph_d),
      .timer_io_pin(timer_io_pin), .adc_start_req(adc_start_req), .match_capture_irq(match_capture_irq),
      .overflow_irq(overflow_irq), .underflow_irq(underflow_irq), .irq_source(irq_source), .irq(irq));
   ptu_enc_model i_ptu_enc_model_1 (.pclk(pclk), .go(go[1]), .up(up), .ph_a(ph_a), .ph_b(ph_b),
      .busy(busy[1]));
   ptu_enc_model i_ptu_enc_model_2 (.pclk(pclk), .go(go[2]), .up(up), .ph_a(ph_c), .ph_b(ph_d),
      .busy(busy[2]));

   // ***************************************************************
   // Clock and converter start monitor
   // ***************************************************************
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      if (adc_start_req[0] === 1'b1)
      begin
         adc_n  <= adc_n + 1;
         t_prev <= t_last;
         t_last <= $time;
      end
   end

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
            output logic err);
      int i;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         n_fail++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle edge so that write side effects have landed when outputs are looked at
      @(posedge pclk);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      check(rd, exp);
      check(32'(err), 32'(experr));
   endtask : rd_chk

   task step(input int ch, input logic dir);
      int i;
      up <= dir;
      go[ch] <= 1'b1;
      @(posedge pclk);
      go <= 2'b00;
      for (i = 0; i < 100; i++)
      begin
         @(posedge pclk);
         if (busy[ch] === 1'b0)
            break;
      end
      if (i == 100)
      begin
         n_fail++;
         tally_and_finish();
      end
      // Input synchroniser and filter latency
      repeat (12) @(posedge pclk);
   endtask : step

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task t_reset;
      check(32'(irq_source), 32'hf);
      check(32'(irq), 32'h0);
      rd_chk(8'h00, 32'h0, 1'b0);
      rd_chk(8'h08, 32'h0, 1'b0);
      rd_chk(8'h0c, 32'h0, 1'b0);
      rd_chk(8'h10, 32'hffff, 1'b0);
      rd_chk(8'h58, 32'h0, 1'b1);
      wr(8'h94, 32'h1234);
      rd_chk(8'h94, 32'h1234, 1'b0);
      rd_chk(8'hc0, 32'h0, 1'b1);
      $display("reset test done");
   endtask : t_reset

   task t_ch1;
      wr(8'h50, 32'h2);
      wr(8'h44, 32'h1);
      wr(8'h40, 32'h9);
      step(1, 1'b1);
      step(1, 1'b1);
      rd_chk(8'h4c, 32'h2, 1'b0);
      rd_chk(8'h48, 32'h40, 1'b0);
      step(1, 1'b1);
      rd_chk(8'h48, 32'h41, 1'b0);
      check(32'(match_capture_irq), 32'h10);
      check(32'(irq_source), 32'h5);
      wr(8'h48, 32'h0);
      check(32'(match_capture_irq), 32'h0);
      step(1, 1'b0);
      step(1, 1'b0);
      rd_chk(8'h4c, 32'h1, 1'b0);
      rd_chk(8'h48, 32'h1, 1'b0);
      wr(8'h48, 32'h0);
      $display("channel 1 test done");
   endtask : t_ch1

   task t_ch2;
      wr(8'h84, 32'h30);
      wr(8'h80, 32'h9);
      step(2, 1'b0);
      rd_chk(8'h8c, 32'hffff, 1'b0);
      check(32'(underflow_irq), 32'h2);
      check(32'(irq_source), 32'hc);
      step(2, 1'b1);
      rd_chk(8'h8c, 32'h0, 1'b0);
      rd_chk(8'h88, 32'h71, 1'b0);
      check(32'(overflow_irq), 32'h4);
      check(32'(irq_source), 32'hb);
      $display("channel 2 test done");
   endtask : t_ch2

   task t_ch0;
      int          i;
      logic [31:0] rd;
      logic        err;
      wr(8'h10, 32'h5);
      wr(8'h04, 32'h41);
      wr(8'h00, 32'h7);
      for (i = 0; i < 200 && adc_n < 3; i++)
         @(posedge pclk);
      check(32'(adc_n >= 3), 32'h1);
      check(32'(t_last - t_prev), 32'd30);
      // Stop the count but keep the level, so the pin must hold
      wr(8'h00, 32'h4);
      check(32'(timer_io_pin), 32'h1);
      check(32'(irq_source), 32'h0);
      wr(8'h08, 32'h0);
      apb(1'b0, 8'h08, 32'h0, rd, err);
      check(rd & 32'h3f, 32'h1);
      wr(8'h08, 32'h0);
      check(32'(match_capture_irq), 32'h0);
      check(32'(irq_source), 32'hb);
      check(32'(irq), 32'h1);
      $display("channel 0 test done");
   endtask : t_ch0

   initial
   begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      go      = 2'b00;
      up      = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ch1();
      t_ch2();
      t_ch0();
      tally_and_finish();
   end
endmodule : ptu_tb_top

// >>> src/ptu_cfg.svh
// Register offsets, field layouts and reset values of the pulse timer unit
`ifndef PTU_CFG_SVH
`define PTU_CFG_SVH
// ***************************************************************
// Channel window: paddr[7:6] picks the channel, low bits the register
// ***************************************************************
`define PTU_CH_MSB       7
`define PTU_CH_LSB       6
`define PTU_OFF_CTRL     6'h00
`define PTU_OFF_IER      6'h04
`define PTU_OFF_SR       6'h08
`define PTU_OFF_CNT      6'h0c
`define PTU_OFF_GR_A     6'h10
`define PTU_OFF_GR_B     6'h14
`define PTU_OFF_GR_C     6'h18
`define PTU_OFF_GR_D     6'h1c
// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define PTU_FLAG_OVF     4
`define PTU_FLAG_UNF     5
`define PTU_FLAGS_CH0    6'h1f
`define PTU_FLAGS_CH12   6'h33
`define PTU_CNT_RST      16'h0000
`define PTU_GR_RST       16'hffff
`define PTU_CNT_MAX      16'hffff
`define PTU_SRC_NONE     4'hf
`endif

// >>> src/ptu_pkg.sv
// Types shared by the pulse timer unit
package ptu_pkg;
   typedef struct packed {
      logic       phase;
      logic       out_level;
      logic       clr_a;
      logic       run;
   } ptu_ctrl_s;
   typedef struct packed {
      logic       trig;
      logic       unf;
      logic       ovf;
      logic [3:0] match;
   } ptu_ier_s;
   typedef struct packed {
      logic       dir;
      logic       unf;
      logic       ovf;
      logic [3:0] match;
   } ptu_flags_s;
   typedef logic [15:0] ptu_word_t;
endpackage : ptu_pkg

// >>> src/ptu_top.sv
// Three-channel 16-bit pulse timer unit with phase counting mode 4 and APB registers
`timescale 1ns/1ps
`include "ptu_cfg.svh"
module ptu_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clock_in_a,
   input  wire logic        ext_clock_in_b,
   input  wire logic        ext_clock_in_c,
   input  wire logic        ext_clock_in_d,
   output logic      [2:0]  timer_io_pin,
   output logic      [2:0]  adc_start_req,
   output logic      [7:0]  match_capture_irq,
   output logic      [2:0]  overflow_irq,
   output logic      [1:0]  underflow_irq,
   output logic      [3:0]  irq_source,
   output logic             irq
);
   // ***************************************************************
   // State
   // ***************************************************************
   ptu_pkg::ptu_ctrl_s  ctrl_reg  [3];
   ptu_pkg::ptu_ctrl_s  ctrl_next [3];
   ptu_pkg::ptu_ier_s   ier_reg   [3];
   ptu_pkg::ptu_ier_s   ier_next  [3];
   ptu_pkg::ptu_flags_s sr_reg    [3];
   ptu_pkg::ptu_flags_s sr_next   [3];
   logic [5:0]          arm_reg   [3];
   logic [5:0]          arm_next  [3];
   ptu_pkg::ptu_word_t  cnt_reg   [3];
   ptu_pkg::ptu_word_t  cnt_next  [3];
   ptu_pkg::ptu_word_t  gr_reg    [3][4];
   ptu_pkg::ptu_word_t  gr_next   [3][4];
   logic [3:0]          match_s   [3];
   logic [2:0]          up_s;
   logic [2:0]          dn_s;
   logic [2:0]          clr_s;
   logic [2:0]          cnt_wr_s;
   logic [2:0]          pin_reg;
   logic [2:0]          pin_next;
   logic [2:0]          adc_reg;
   logic [2:0]          adc_next;
   logic [31:0]         rdata_reg;
   logic [31:0]         rdata_next;
   logic [3:0]          sync1_reg;
   logic [3:0]          sync2_reg;
   logic [3:0]          sync3_reg;
   logic [3:0]          filt_reg;
   logic [3:0]          filt_next;
   logic [3:0]          filt_d_reg;
   logic                wr_acc;
   logic                rd_acc;
   logic [1:0]          acc_ch;
   logic [5:0]          acc_off;
   logic                bad_addr;

   assign acc_ch  = paddr[`PTU_CH_MSB:`PTU_CH_LSB];
   assign acc_off = paddr[5:0];
   // GR C/D exist only on channel 0
   assign bad_addr = (acc_ch == 2'h3) || (paddr[1:0] != 2'h0) || (acc_off > `PTU_OFF_GR_D) ||
                     ((acc_ch != 2'h0) && (acc_off >= `PTU_OFF_GR_C));
   assign wr_acc  = psel && penable && pwrite && !bad_addr;
   assign rd_acc  = psel && penable && !pwrite && !bad_addr;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && bad_addr;
   assign prdata  = rdata_reg;

   // ***************************************************************
   // Encoder inputs: three stages, a change counts when stages 2 and 3 agree
   // ***************************************************************
   // Narrow glitches never reach the edge logic; this is why pulses must be
   // wider than a few states.
   always_comb
      filt_next = (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);

   // ***************************************************************
   // Counters, flags and register writes
   // ***************************************************************
   always_comb
   begin
      logic [5:0] valid;
      logic [5:0] set_m;
      logic [5:0] clr_m;
      logic       a_lvl;
      logic       b_edge;
      logic       b_now;
      valid = 6'h00;
      set_m = 6'h00;
      clr_m = 6'h00;
      a_lvl = 1'b0;
      b_edge = 1'b0;
      b_now = 1'b0;
      pin_next = pin_reg;
      adc_next = 3'h0;
      rdata_next = rdata_reg;
      for (int c = 0; c < 3; c++)
      begin
         ctrl_next[c] = ctrl_reg[c];
         ier_next[c]  = ier_reg[c];
         sr_next[c]   = sr_reg[c];
         arm_next[c]  = arm_reg[c];
         cnt_next[c]  = cnt_reg[c];
         for (int k = 0; k < 4; k++)
            gr_next[c][k] = gr_reg[c][k];
         valid = (c == 0) ? `PTU_FLAGS_CH0 : `PTU_FLAGS_CH12;
         // Count sources: internal every cycle, or mode 4 on channels 1 and 2
         up_s[c] = 1'b0;
         dn_s[c] = 1'b0;
         if (ctrl_reg[c].run)
         begin
            if (c != 0 && ctrl_reg[c].phase)
            begin
               a_lvl  = filt_reg[2*c-2];
               b_now  = filt_reg[2*c-1];
               b_edge = filt_reg[2*c-1] ^ filt_d_reg[2*c-1];
               up_s[c] = b_edge && (b_now == a_lvl);
               dn_s[c] = b_edge && (b_now != a_lvl);
            end
            else
               up_s[c] = 1'b1;
         end
         // Match only as the count leaves the equal value, once per input clock
         for (int k = 0; k < 4; k++)
            match_s[c][k] = (up_s[c] || dn_s[c]) && (cnt_reg[c] == gr_reg[c][k]) && valid[k];
         clr_s[c]    = ctrl_reg[c].clr_a && match_s[c][0];
         cnt_wr_s[c] = wr_acc && (acc_ch == 2'(c)) && (acc_off == `PTU_OFF_CNT);
         set_m = {6{1'b0}};
         set_m[3:0] = match_s[c];
         // Clearing and a counter write both hide a wrap
         set_m[`PTU_FLAG_OVF] = up_s[c] && (cnt_reg[c] == `PTU_CNT_MAX) && !clr_s[c] && !cnt_wr_s[c];
         set_m[`PTU_FLAG_UNF] = dn_s[c] && (cnt_reg[c] == `PTU_CNT_RST) && !clr_s[c] && !cnt_wr_s[c];
         set_m = set_m & valid;
         if (clr_s[c])
            cnt_next[c] = `PTU_CNT_RST;
         else if (cnt_wr_s[c])
            cnt_next[c] = pwdata[15:0];
         else if (up_s[c])
            cnt_next[c] = cnt_reg[c] + 16'h0001;
         else if (dn_s[c])
            cnt_next[c] = cnt_reg[c] - 16'h0001;
         if (up_s[c] || dn_s[c])
            sr_next[c].dir = up_s[c];
         if (match_s[c][0])
         begin
            pin_next[c] = ctrl_reg[c].out_level;
            adc_next[c] = ier_reg[c].trig;
         end
         // Flag clear: only bits read as one since the last status write
         clr_m = 6'h00;
         if (rd_acc && (acc_ch == 2'(c)) && (acc_off == `PTU_OFF_SR))
            arm_next[c] = rdata_reg[5:0];
         if (wr_acc && (acc_ch == 2'(c)))
         begin
            case (acc_off)
               `PTU_OFF_CTRL:
               begin
                  ctrl_next[c] = pwdata[3:0];
                  if (c == 0)
                     ctrl_next[c].phase = 1'b0;
               end
               `PTU_OFF_IER:
               begin
                  ier_next[c] = pwdata[6:0];
                  ier_next[c][5:0] = pwdata[5:0] & valid;
               end
               `PTU_OFF_SR:
               begin
                  clr_m = arm_reg[c] & ~pwdata[5:0];
                  arm_next[c] = 6'h00;
               end
               `PTU_OFF_GR_A: gr_next[c][0] = pwdata[15:0];
               `PTU_OFF_GR_B: gr_next[c][1] = pwdata[15:0];
               `PTU_OFF_GR_C: gr_next[c][2] = pwdata[15:0];
               `PTU_OFF_GR_D: gr_next[c][3] = pwdata[15:0];
               default: ;
            endcase
         end
         // A new event outweighs a clear in the same cycle
         sr_next[c][5:0] = (sr_reg[c][5:0] & ~clr_m) | set_m;
      end
      // Read data latched in the setup phase, so the access phase needs no wait
      if (psel && !penable && !pwrite)
      begin
         rdata_next = 32'h0000_0000;
         if (!bad_addr)
            case (acc_off)
               `PTU_OFF_CTRL: rdata_next = {28'h0, ctrl_reg[acc_ch]};
               `PTU_OFF_IER:  rdata_next = {25'h0, ier_reg[acc_ch]};
               `PTU_OFF_SR:   rdata_next = {25'h0, sr_reg[acc_ch]};
               `PTU_OFF_CNT:  rdata_next = {16'h0, cnt_reg[acc_ch]};
               `PTU_OFF_GR_A: rdata_next = {16'h0, gr_reg[acc_ch][0]};
               `PTU_OFF_GR_B: rdata_next = {16'h0, gr_reg[acc_ch][1]};
               `PTU_OFF_GR_C: rdata_next = {16'h0, gr_reg[acc_ch][2]};
               `PTU_OFF_GR_D: rdata_next = {16'h0, gr_reg[acc_ch][3]};
               default:       rdata_next = 32'h0000_0000;
            endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < 3; c++)
         begin
            ctrl_reg[c] <= '0;
            ier_reg[c]  <= '0;
            sr_reg[c]   <= '0;
            arm_reg[c]  <= 6'h00;
            cnt_reg[c]  <= `PTU_CNT_RST;
            for (int k = 0; k < 4; k++)
               gr_reg[c][k] <= `PTU_GR_RST;
         end
         pin_reg    <= 3'h0;
         adc_reg    <= 3'h0;
         rdata_reg  <= 32'h0000_0000;
         sync1_reg  <= 4'h0;
         sync2_reg  <= 4'h0;
         sync3_reg  <= 4'h0;
         filt_reg   <= 4'h0;
         filt_d_reg <= 4'h0;
      end
      else
      begin
         ctrl_reg   <= ctrl_next;
         ier_reg    <= ier_next;
         sr_reg     <= sr_next;
         arm_reg    <= arm_next;
         cnt_reg    <= cnt_next;
         gr_reg     <= gr_next;
         pin_reg    <= pin_next;
         adc_reg    <= adc_next;
         rdata_reg  <= rdata_next;
         sync1_reg  <= {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         filt_reg   <= filt_next;
         filt_d_reg <= filt_reg;
      end
   end

   // ***************************************************************
   // Interrupt requests, priority and converter trigger
   // ***************************************************************
   logic [12:0] req_vec;
   always_comb
   begin
      for (int c = 0; c < 3; c++)
         overflow_irq[c] = sr_reg[c].ovf && ier_reg[c].ovf;
      match_capture_irq[3:0] = sr_reg[0].match & ier_reg[0].match;
      match_capture_irq[5:4] = sr_reg[1].match[1:0] & ier_reg[1].match[1:0];
      match_capture_irq[7:6] = sr_reg[2].match[1:0] & ier_reg[2].match[1:0];
      underflow_irq[0] = sr_reg[1].unf && ier_reg[1].unf;
      underflow_irq[1] = sr_reg[2].unf && ier_reg[2].unf;
      req_vec = {underflow_irq[1], overflow_irq[2], match_capture_irq[7:6],
                 underflow_irq[0], overflow_irq[1], match_capture_irq[5:4],
                 overflow_irq[0], match_capture_irq[3:0]};
      // Lowest index wins: channel 0 register A first
      irq_source = `PTU_SRC_NONE;
      for (int i = 12; i >= 0; i--)
         if (req_vec[i])
            irq_source = 4'(i);
      irq = |req_vec;
   end
   assign timer_io_pin  = pin_reg;
   assign adc_start_req = adc_reg;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_phase_up_count: assert property (ctrl_reg[1].run && ctrl_reg[1].phase && filt_reg[1] && !filt_d_reg[1]
                                      && filt_reg[0] |-> up_s[1] && !dn_s[1])
      else $error("mode 4 up count missed");
   a_phase_down_cnt: assert property (ctrl_reg[1].run && ctrl_reg[1].phase && !filt_reg[1] && filt_d_reg[1]
                                      && filt_reg[0] |-> dn_s[1] && !up_s[1])
      else $error("mode 4 down count missed");
   a_irq_follows: assert property (sr_reg[2].ovf && ier_reg[2].ovf |-> overflow_irq[2] && irq)
      else $error("enabled flag gives no request");
   a_irq_holds: assert property (overflow_irq[2] && !(wr_acc && acc_ch == 2'h2) |=> overflow_irq[2])
      else $error("request dropped without clear");
   a_prio_top: assert property (match_capture_irq[0] |-> irq_source == 4'h0)
      else $error("channel 0 A not top priority");
   a_no_unf_ch0: assert property (!sr_reg[0].unf && !sr_reg[1].match[2])
      else $error("flag on absent source");
   a_adc_request: assert property (match_s[0][0] && ier_reg[0].trig |=> adc_start_req[0])
      else $error("converter start missing");
   a_match_leave: assert property (match_s[0][0] |-> (up_s[0] || dn_s[0]) && cnt_reg[0] == gr_reg[0][0])
      else $error("match outside a count step");
   a_match_once: assert property (!up_s[2] && !dn_s[2] |-> match_s[2] == 4'h0)
      else $error("match without input clock");
   a_clear_arm: assert property (wr_acc && acc_ch == 2'h0 && acc_off == `PTU_OFF_SR && !arm_reg[0][0]
                                 && sr_reg[0].match[0] |=> sr_reg[0].match[0])
      else $error("flag cleared without read");
   a_period_clear: assert property (clr_s[0] |=> cnt_reg[0] == `PTU_CNT_RST)
      else $error("clear on match failed");
   a_dir_flag: assert property (up_s[2] || dn_s[2] |=> sr_reg[2].dir == $past(up_s[2]))
      else $error("direction flag wrong");
   a_set_wins: assert property (match_s[0][0] |=> sr_reg[0].match[0])
      else $error("match flag lost");

   c_phase_up:   cover property (up_s[1] && ctrl_reg[1].phase);
   c_underflow:  cover property (sr_reg[2].unf);
   c_adc_start:  cover property (adc_start_req[0]);
   c_flag_clear: cover property (sr_reg[0].match[0] ##1 !sr_reg[0].match[0]);
endmodule : ptu_top
